//--- common/flow_totalizer_defs.svh
// Purpose: Offsets, fields, reset values and timing for the flow totalizer
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Q16.16 fixed point for 32-bit values, 64-bit totals carry 16 fraction bits, 1.0 = 32'h0001_0000
`ifndef FLOW_TOTALIZER_DEFS_SVH
`define FLOW_TOTALIZER_DEFS_SVH

`define FT_CLK_HZ        64'd125000000
`define FT_UPDATE_MS     64'd33
`define FT_MISSED_CYCLES 64'd2
`define FT_STARTUP_S     64'd40
`define FT_FRAC          16
`define FT_ONE           32'h0001_0000

// Word indices (byte address = 4 * index, plus 0x80 for result words)
`define FT_IX_CTRL       5'h00
`define FT_IX_CMD        5'h01
`define FT_IX_CFG1       5'h03
`define FT_IX_CFG2       5'h04
`define FT_IX_GAIN       5'h05
`define FT_IX_OFFSET     5'h06
`define FT_IX_MUNIT      5'h07
`define FT_IX_VUNIT      5'h08
`define FT_IX_PRE1_LO    5'h09
`define FT_IX_PRE1_HI    5'h0A
`define FT_IX_PRE2_LO    5'h0B
`define FT_IX_PRE2_HI    5'h0C
`define FT_IX_COEF0      5'h10
`define FT_IX_STATUS     5'h02
`define FT_IX_PCT        5'h00
`define FT_IX_FA         5'h01
`define FT_IX_FB         5'h02
`define FT_IX_MASS       5'h03
`define FT_IX_VOL        5'h04
`define FT_IX_T1_LO      5'h05
`define FT_IX_T1_HI      5'h06
`define FT_IX_T2_LO      5'h07
`define FT_IX_T2_HI      5'h08
`define FT_IX_T1_S       5'h09
`define FT_IX_T2_S       5'h0A
`define FT_RESULT_BIT    7

// Field positions
`define FT_CTRL_BATCH    0
`define FT_CMD_TGT       1:0
`define FT_CMD_OP        3:2
`define FT_CFG_SEL       2:0
`define FT_CFG_DIR       5:4
`define FT_CFG_FAIL      9:8
`define FT_CFG_RESET     32'h0000_0021

// Encodings
`define FT_SRC_MASS      3'h1
`define FT_SRC_FA        3'h2
`define FT_SRC_FB        3'h3
`define FT_SRC_VOL       3'h4
`define FT_DIR_REV       2'h0
`define FT_DIR_FWD       2'h1
`define FT_FAIL_RUN      2'h0
`define FT_FAIL_HOLD     2'h1
`define FT_FAIL_MEM      2'h2
`define FT_OP_RESET      2'h0
`define FT_OP_HOLD       2'h1
`define FT_OP_CONT       2'h2
`define FT_OP_PRESET     2'h3

`endif

//--- common/flow_totalizer_pkg.sv
// Purpose: Types shared by the flow totalizer
// Assumes: Q16.16 signed values
// Notes:   All block state sits in state_t
package flow_totalizer_pkg;
    typedef logic signed [31:0] q_t;
    typedef logic [1:0][63:0]   tot_pair_t;

    typedef struct packed {
        q_t mass;
        q_t volume;
        q_t temp;
        q_t dens;
    } fe_sample_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FRAC = 2'b01,
        PH_FLOW = 2'b10,
        PH_SUM  = 2'b11
    } phase_t;

    typedef struct packed {
        phase_t           phase;
        logic [31:0][31:0] cfg;
        fe_sample_t       fe;
        q_t               pct;
        q_t               fa;
        q_t               fb;
        logic [10:0][31:0] res;
        tot_pair_t        tot;
        logic [1:0][31:0] last_good;
        logic [1:0]       held;
        logic             started;
        logic [39:0]      start_cnt;
        logic [39:0]      wd_cnt;
        logic             wd_err;
        logic             ack;
        logic [31:0]      rdata;
        logic             nv_store;
    } state_t;
endpackage

//--- design/flow_totalizer.sv
// Purpose: Fraction, unit conversion and two 64-bit flow totalizers
// Assumes: One clock; front-end strobe i_fe_valid with a sample each update
// Notes:   Registers over classic Wishbone, one wait state per access
// What this block does
// R1 - Recompute all values on each front-end update
// R2 - Flag timeout after two missed updates
// R3 - Convert outputs to configured units first; totals sum unscaled values, and only the 32-bit total is scaled afterwards
// R4 - Percent equals offset plus gain times polynomial
// R5 - Twelve-coefficient polynomial in temperature and density
// R6 - Gain resets to one, offset to zero
// R7 - Fraction basis is a read-only sensor input
// R8 - Fraction A/B flows from base and percent
// R9 - Two independent totalizers with four sources
// R10 - Source codes 1 mass to 4 volume
// R11 - Direction codes reverse, forward, net
// R12 - Each totalizer is a 64-bit accumulator
// R13 - Fail mode picks actual, zero or last good
// R14 - Group error keeps summing a fixed delta
// R15 - Totals offered wide and as 32-bit value
// R16 - Hold stops, continue resumes from held value
// R17 - Commands address one or both totalizers
// R18 - Totalizers halted during start-up transient
// R19 - Totals handed to nonvolatile store, restorable
// R20 - Host holds and resets before source change
// R21 - Reset clears, preset loads, both restart
// R22 - Batch mode locks totalizer 2 settings, commands
// R23 - Direction filter drops unwanted sign increments
// R24 - Timeout error clears when data returns
`include "flow_totalizer_defs.svh"

module flow_totalizer #(
    parameter logic [39:0] WD_CYCLES      = 40'((`FT_MISSED_CYCLES * `FT_UPDATE_MS
                                                * `FT_CLK_HZ) / 64'd1000),
    parameter logic [39:0] STARTUP_CYCLES = 40'(`FT_STARTUP_S * `FT_CLK_HZ)
) (
    input  wire logic                            i_clk,
    input  wire logic                            i_arst_n,
    input  wire logic                            i_wb_cyc,
    input  wire logic                            i_wb_stb,
    input  wire logic                            i_wb_we,
    input  wire logic [7:0]                      i_wb_adr,
    input  wire logic [3:0]                      i_wb_sel,
    input  wire logic [31:0]                     i_wb_dat,
    output logic      [31:0]                     o_wb_dat,
    output logic                                 o_wb_ack,
    input  wire logic                            i_fe_valid,
    input  wire flow_totalizer_pkg::fe_sample_t  i_fe,
    input  wire logic                            i_group_error,
    input  wire logic                            i_fraction_basis_volume,
    input  wire logic                            i_nv_load,
    input  wire flow_totalizer_pkg::tot_pair_t   i_nv_tot,
    output logic                                 o_nv_store,
    output flow_totalizer_pkg::tot_pair_t        o_nv_tot,
    output logic                                 o_frontend_timeout_error
);

    flow_totalizer_pkg::state_t s;
    flow_totalizer_pkg::state_t next_s;

    function automatic flow_totalizer_pkg::q_t mulq(input flow_totalizer_pkg::q_t a,
                                                     input flow_totalizer_pkg::q_t b);
        logic signed [63:0] p;
        p = a * b;
        return p[`FT_FRAC+31:`FT_FRAC];
    endfunction

    // Inner quadratics in temperature, then Horner in density
    function automatic flow_totalizer_pkg::q_t poly(input logic [11:0][31:0] c,
                                                     input flow_totalizer_pkg::q_t t,
                                                     input flow_totalizer_pkg::q_t d);
        flow_totalizer_pkg::q_t acc;
        flow_totalizer_pkg::q_t inner;
        acc = '0;
        for (int k = 3; k >= 0; k--)
        begin
            inner = c[3*k] + mulq(t, c[3*k+1] + mulq(t, c[3*k+2])); // see R5
            acc   = inner + mulq(d, acc);
        end
        return acc;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic                   bus_req;
    logic                   wr;
    logic [4:0]             ix;
    logic                   batch;
    logic [31:0]            cfgk;
    flow_totalizer_pkg::q_t src;
    flow_totalizer_pkg::q_t inc;
    flow_totalizer_pkg::q_t base;
    flow_totalizer_pkg::q_t uscale;
    logic                   grp;

    always_comb
    begin
        next_s   = s;
        next_s.ack      = 1'b0;
        next_s.nv_store = 1'b0;
        bus_req  = i_wb_cyc && i_wb_stb && !s.ack;
        wr       = bus_req && i_wb_we && !i_wb_adr[`FT_RESULT_BIT];
        ix       = i_wb_adr[6:2];
        batch    = s.cfg[`FT_IX_CTRL][`FT_CTRL_BATCH];
        grp      = i_group_error || s.wd_err;
        cfgk     = '0;
        src      = '0;
        inc      = '0;
        base     = '0;
        uscale   = '0;

        // Front-end watchdog
        if (i_fe_valid)
        begin
            next_s.wd_cnt = '0;
            next_s.wd_err = 1'b0;                                   // see R24
        end
        else if (s.wd_cnt >= WD_CYCLES - 40'h1)
        begin
            next_s.wd_err = 1'b1;                                   // see R2
        end
        else
        begin
            next_s.wd_cnt = s.wd_cnt + 40'h1;
        end

        // Start-up halt, counted from reset release
        if (!s.started)
        begin
            next_s.start_cnt = s.start_cnt + 40'h1;
            if (s.start_cnt >= STARTUP_CYCLES - 40'h1)
            begin
                next_s.started = 1'b1;                              // see R18
            end
        end

        unique case (s.phase)
            flow_totalizer_pkg::PH_IDLE:
            begin
                if (i_fe_valid)
                begin
                    next_s.fe    = i_fe;                            // see R1
                    next_s.phase = flow_totalizer_pkg::PH_FRAC;
                end
            end
            flow_totalizer_pkg::PH_FRAC:
            begin
                next_s.pct = s.cfg[`FT_IX_OFFSET]
                           + mulq(s.cfg[`FT_IX_GAIN],
                                  poly(s.cfg[`FT_IX_COEF0 +: 12], s.fe.temp, s.fe.dens)); // see R4
                next_s.phase = flow_totalizer_pkg::PH_FLOW;
            end
            flow_totalizer_pkg::PH_FLOW:
            begin
                base = i_fraction_basis_volume ? s.fe.volume : s.fe.mass; // see R7
                next_s.fa = mulq(base, s.pct);                      // see R8
                next_s.fb = base - mulq(base, s.pct);               // see R8
                next_s.phase = flow_totalizer_pkg::PH_SUM;
            end
            flow_totalizer_pkg::PH_SUM:
            begin
                for (int k = 0; k < 2; k++)                         // see R9
                begin
                    cfgk = s.cfg[`FT_IX_CFG1 + 5'(k)];
                    unique case (cfgk[`FT_CFG_SEL])                 // see R10
                        `FT_SRC_MASS: src = s.fe.mass;
                        `FT_SRC_FA:   src = s.fa;
                        `FT_SRC_FB:   src = s.fb;
                        `FT_SRC_VOL:  src = s.fe.volume;
                        default:      src = '0;
                    endcase
                    inc = src;
                    if (grp)
                    begin
                        unique case (cfgk[`FT_CFG_FAIL])            // see R13
                            `FT_FAIL_HOLD: inc = '0;
                            `FT_FAIL_MEM:  inc = s.last_good[k];    // see R14
                            default:       inc = src;
                        endcase
                    end
                    else
                    begin
                        next_s.last_good[k] = src;
                    end
                    if ((cfgk[`FT_CFG_DIR] == `FT_DIR_FWD && inc < 0)
                        || (cfgk[`FT_CFG_DIR] == `FT_DIR_REV && inc > 0))
                    begin
                        inc = '0;                                   // see R11, R23
                    end
                    if (s.started && !s.held[k])                    // see R16, R18
                    begin
                        next_s.tot[k] = s.tot[k] + 64'(signed'(inc)); // see R12
                    end
                    uscale = (cfgk[`FT_CFG_SEL] == `FT_SRC_VOL
                              || (cfgk[`FT_CFG_SEL] != `FT_SRC_MASS && i_fraction_basis_volume))
                           ? s.cfg[`FT_IX_VUNIT] : s.cfg[`FT_IX_MUNIT];
                    next_s.res[`FT_IX_T1_S + 5'(k)] =
                        mulq(next_s.tot[k][31:0], uscale);  // see R15, R3
                end
                uscale = i_fraction_basis_volume ? s.cfg[`FT_IX_VUNIT] : s.cfg[`FT_IX_MUNIT];
                next_s.res[`FT_IX_PCT]  = s.pct;
                next_s.res[`FT_IX_FA]   = mulq(s.fa, uscale);       // see R3
                next_s.res[`FT_IX_FB]   = mulq(s.fb, uscale);
                next_s.res[`FT_IX_MASS] = mulq(s.fe.mass, s.cfg[`FT_IX_MUNIT]);
                next_s.res[`FT_IX_VOL]  = mulq(s.fe.volume, s.cfg[`FT_IX_VUNIT]);
                next_s.res[`FT_IX_T1_LO] = next_s.tot[0][31:0];     // see R15
                next_s.res[`FT_IX_T1_HI] = next_s.tot[0][63:32];
                next_s.res[`FT_IX_T2_LO] = next_s.tot[1][31:0];
                next_s.res[`FT_IX_T2_HI] = next_s.tot[1][63:32];
                next_s.nv_store = 1'b1;                             // see R19
                next_s.phase    = flow_totalizer_pkg::PH_IDLE;
            end
        endcase

        // Restore from nonvolatile memory after restart
        if (i_nv_load)
        begin
            next_s.tot = i_nv_tot;                                  // see R19
        end

        // Bus access; commands override the same cycle's summation
        if (bus_req)
        begin
            next_s.ack   = 1'b1;
            next_s.rdata = '0;
            if (i_wb_adr[`FT_RESULT_BIT])
            begin
                if (ix <= `FT_IX_T2_S)
                begin
                    next_s.rdata = s.res[ix[3:0]];
                end
            end
            else if (ix == `FT_IX_STATUS)
            begin
                next_s.rdata = {25'h0, i_fraction_basis_volume, grp, s.held,
                                s.started, s.wd_err, batch};
            end
            else if (ix != `FT_IX_CMD)
            begin
                next_s.rdata = s.cfg[ix];
            end
        end
        // Locking totalizer 2 blocks its settings during batching
        if (wr && ix != `FT_IX_CMD && ix != `FT_IX_STATUS
            && !(batch && (ix == `FT_IX_CFG2 || ix == `FT_IX_PRE2_LO
                           || ix == `FT_IX_PRE2_HI)))              // see R22
        begin
            next_s.cfg[ix] = merge(s.cfg[ix], i_wb_dat, i_wb_sel);  // see R6
        end
        if (wr && ix == `FT_IX_CMD && i_wb_sel[0])
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (i_wb_dat[k] && !(k == 1 && batch))              // see R17, R22
                begin
                    unique case (i_wb_dat[`FT_CMD_OP])
                        `FT_OP_RESET:
                        begin
                            next_s.tot[k]  = '0;                    // see R21
                            next_s.held[k] = 1'b0;
                        end
                        `FT_OP_HOLD:   next_s.held[k] = 1'b1;       // see R16
                        `FT_OP_CONT:   next_s.held[k] = 1'b0;       // see R16
                        `FT_OP_PRESET:
                        begin
                            next_s.tot[k]  = {s.cfg[`FT_IX_PRE1_HI + 5'(2*k)],
                                              s.cfg[`FT_IX_PRE1_LO + 5'(2*k)]}; // see R21
                            next_s.held[k] = 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s                       <= '0;
            s.phase                 <= flow_totalizer_pkg::PH_IDLE;
            s.cfg[`FT_IX_GAIN]      <= `FT_ONE;                     // see R6
            s.cfg[`FT_IX_MUNIT]     <= `FT_ONE;
            s.cfg[`FT_IX_VUNIT]     <= `FT_ONE;
            s.cfg[`FT_IX_CFG1]      <= `FT_CFG_RESET;
            s.cfg[`FT_IX_CFG2]      <= `FT_CFG_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_wb_ack                 = s.ack;
    assign o_wb_dat                 = s.rdata;
    assign o_nv_store               = s.nv_store;
    assign o_nv_tot                 = s.tot;
    assign o_frontend_timeout_error = s.wd_err;

endmodule

//--- bench/flow_totalizer_sva.sv
// Purpose: Port-level checks for the flow totalizer
// Assumes: Front-end strobes come at least 4 cycles apart
// Notes:   Long waits are counted in helper logic, not unrolled
module flow_totalizer_sva #(
    parameter logic [39:0] WD_CYCLES      = 40'h28,
    parameter logic [39:0] STARTUP_CYCLES = 40'h14
) (
    input wire logic                          i_clk,
    input wire logic                          i_arst_n,
    input wire logic                          i_wb_cyc,
    input wire logic                          i_wb_stb,
    input wire logic                          o_wb_ack,
    input wire logic                          i_fe_valid,
    input wire logic                          i_nv_load,
    input wire logic                          o_nv_store,
    input wire flow_totalizer_pkg::tot_pair_t o_nv_tot,
    input wire logic                          o_frontend_timeout_error
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [39:0] quiet;
    logic [39:0] age;

    // No saturation: a run is far shorter than 2^40 cycles
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            quiet <= 40'h0;
            age   <= 40'h0;
        end
        else
        begin
            quiet <= i_fe_valid ? 40'h0 : quiet + 40'h1;
            age   <= age + 40'h1;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered after one cycle");
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    chk_store_delay: assert property (i_fe_valid |-> ##4 o_nv_store)
        else $error("update not finished four cycles after strobe");
    chk_store_cause: assert property (o_nv_store |-> $past(i_fe_valid, 4))
        else $error("store pulse without a strobe four cycles earlier");
    chk_tot_quiet: assert property (!o_nv_store && !o_wb_ack && !$past(i_nv_load)
        |-> $stable(o_nv_tot))
        else $error("totals moved outside an update, command or load");
    chk_start_halt: assert property (age < STARTUP_CYCLES - 40'h4 && o_nv_store
        && !o_wb_ack |-> $stable(o_nv_tot))
        else $error("totals moved during the start-up halt");
    chk_wd_quiet: assert property (quiet > 40'h1 && quiet < WD_CYCLES - 40'h1
        |-> !o_frontend_timeout_error)
        else $error("timeout raised too early");
    chk_wd_raise: assert property (quiet == WD_CYCLES + 40'h2 |-> o_frontend_timeout_error)
        else $error("timeout missing after missed updates");
    chk_wd_clear: assert property (i_fe_valid |=> !o_frontend_timeout_error)
        else $error("timeout not cleared by new data");

    cover property (o_wb_ack);
    cover property ($rose(o_frontend_timeout_error));
    cover property (o_nv_store && $changed(o_nv_tot));
endmodule

bind flow_totalizer flow_totalizer_sva #(
    .WD_CYCLES      (WD_CYCLES),
    .STARTUP_CYCLES (STARTUP_CYCLES)
) flow_totalizer_sva_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .i_fe_valid(i_fe_valid), .i_nv_load(i_nv_load),
    .o_nv_store(o_nv_store), .o_nv_tot(o_nv_tot),
    .o_frontend_timeout_error(o_frontend_timeout_error)
);

//--- bench/frontend_model.sv
// Purpose: Measurement front-end stand-in, one sample per update
// Assumes: Bench raises i_send for one cycle per update
// Notes:   Sample lines invert between strobes so stale data never looks valid
module frontend_model (
    input  wire logic                           i_clk,
    input  wire logic                           i_arst_n,
    input  wire logic                           i_send,
    input  wire flow_totalizer_pkg::fe_sample_t i_sample,
    output logic                                o_fe_valid,
    output flow_totalizer_pkg::fe_sample_t      o_fe
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_fe_valid <= 1'b0;
            o_fe       <= '0;
        end
        else
        begin
            o_fe_valid <= i_send;
            o_fe       <= i_send ? i_sample : ~o_fe;
        end
    end
endmodule

//--- bench/test_flow_totalizer.sv
// Purpose: Directed bench for the flow totalizer over Wishbone
// Assumes: Short watchdog and start-up counts for simulation
// Notes:   Expected Q16.16 polynomial terms are worked out beside the coefficient writes
module test_flow_totalizer;
    timeunit 1ns;
    timeprecision 1ps;

    logic                           i_clk;
    logic                           i_arst_n;
    logic                           req;
    logic                           we;
    logic                           send;
    logic                           grp;
    logic                           basis;
    logic                           nv_load;
    logic [7:0]                     adr;
    logic [31:0]                    wdat;
    logic [31:0]                    rdat;
    logic [31:0]                    wb_dat;
    logic                           wb_ack;
    logic                           fe_valid;
    logic                           nv_store;
    logic                           wd_err;
    flow_totalizer_pkg::fe_sample_t smp;
    flow_totalizer_pkg::fe_sample_t fe;
    flow_totalizer_pkg::tot_pair_t  nv_in;
    flow_totalizer_pkg::tot_pair_t  nv_out;
    logic [63:0]                    src_inc [1:4];
    int                             fail_count;
    int                             checks;

    flow_totalizer #(.WD_CYCLES(40'h40), .STARTUP_CYCLES(40'h14)) flow_totalizer_inst (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(wb_dat),
        .o_wb_ack(wb_ack), .i_fe_valid(fe_valid), .i_fe(fe), .i_group_error(grp),
        .i_fraction_basis_volume(basis), .i_nv_load(nv_load), .i_nv_tot(nv_in),
        .o_nv_store(nv_store), .o_nv_tot(nv_out), .o_frontend_timeout_error(wd_err)
    );

    frontend_model frontend_model_inst (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_send(send), .i_sample(smp),
        .o_fe_valid(fe_valid), .o_fe(fe)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic guard(input logic ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("unexpected timeout at %0t: got 0 expected 1", $time);
            wrap_up();
        end
    endtask

    // Request held until ack is sampled, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
            @(posedge i_clk);
        while (wb_ack !== 1'b1 && ++n < 20);
        guard(wb_ack);
        rdat = wb_dat;
        req <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp({32'h0, rdat}, {32'h0, e});
    endtask

    task automatic tot_chk(input int t, input logic [63:0] e);
        logic [31:0] lo;
        wb(1'b0, 8'h94 + 8'(8 * t), 32'h0);
        lo = rdat;
        wb(1'b0, 8'h98 + 8'(8 * t), 32'h0);
        cmp({rdat, lo}, e);
    endtask

    task automatic cmd(input logic [1:0] t, input logic [1:0] op);
        wb(1'b1, 8'h04, {28'h0, op, t});
    endtask

    // One update with the given mass, then wait for the store pulse
    task automatic upd(input flow_totalizer_pkg::q_t m);
        int n;
        n = 0;
        @(posedge i_clk);
        smp.mass <= m;
        send     <= 1'b1;
        @(posedge i_clk);
        send <= 1'b0;
        do
            @(posedge i_clk);
        while (nv_store !== 1'b1 && ++n < 20);
        guard(nv_store);
    endtask

    initial
    begin
        {req, we, send, grp, basis, nv_load} = 6'h0;
        adr        = 8'h0;
        wdat       = 32'h0;
        nv_in      = '0;
        smp        = '{32'h0004_0000, 32'h0002_0000, 32'h0002_0000, 32'h0000_8000};
        src_inc    = '{64'h4_0000, 64'h3_0000, 64'h1_0000, 64'h2_0000};
        fail_count = 0;
        checks     = 0;
        i_arst_n   = 1'b0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        upd(32'h0004_0000);
        tot_chk(0, 64'h0);
        rd_chk(8'h14, 32'h0001_0000);
        rd_chk(8'h18, 32'h0);
        rd_chk(8'h0C, 32'h21);
        rd_chk(8'hFC, 32'h0);
        wb(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd_chk(8'h08, 32'h4);
        $display("test reset_values done");
        wb(1'b1, 8'h40, 32'h2000);          // c0 = 0.125
        wb(1'b1, 8'h44, 32'h1000);          // c1*T = 0.125
        wb(1'b1, 8'h50, 32'h4000);          // c4*T*rho = 0.25
        wb(1'b1, 8'h6C, 32'h4000);          // c11*T^2*rho^3 = 0.125
        wb(1'b1, 8'h18, 32'h2000);          // Offset 0.125
        upd(32'h0004_0000);
        rd_chk(8'h80, 32'hC000);
        rd_chk(8'h84, 32'h3_0000);
        rd_chk(8'h88, 32'h1_0000);
        wb(1'b1, 8'h1C, 32'h2_0000);
        upd(32'h0004_0000);
        rd_chk(8'h8C, 32'h8_0000);
        wb(1'b1, 8'h1C, 32'h1_0000);
        basis <= 1'b1;
        upd(32'h0004_0000);
        rd_chk(8'h84, 32'h1_8000);
        basis <= 1'b0;
        $display("test fraction done");
        for (int s = 1; s <= 4; s++)
        begin
            cmd(2'h3, 2'h1);
            wb(1'b1, 8'h0C, 32'h20 | 32'(s));
            cmd(2'h3, 2'h0);
            cmd(2'h3, 2'h2);
            upd(32'h0004_0000);
            tot_chk(0, src_inc[s]);
        end
        tot_chk(1, 64'h4_0000);
        wb(1'b1, 8'h0C, 32'h11);
        wb(1'b1, 8'h10, 32'h01);
        cmd(2'h3, 2'h0);
        upd(32'hFFFF_0000);
        tot_chk(0, 64'h0);
        tot_chk(1, 64'hFFFF_FFFF_FFFF_0000);
        upd(32'h0004_0000);
        tot_chk(0, 64'h4_0000);
        tot_chk(1, 64'hFFFF_FFFF_FFFF_0000);
        $display("test direction done");
        wb(1'b1, 8'h0C, 32'h21);
        wb(1'b1, 8'h10, 32'h21);
        cmd(2'h3, 2'h0);
        cmd(2'h3, 2'h1);
        upd(32'h0004_0000);
        tot_chk(0, 64'h0);
        cmd(2'h1, 2'h2);
        upd(32'h0004_0000);
        tot_chk(0, 64'h4_0000);
        tot_chk(1, 64'h0);
        wb(1'b1, 8'h24, 32'h0005_0000);
        wb(1'b1, 8'h28, 32'h1);
        cmd(2'h1, 2'h3);
        upd(32'h0);
        tot_chk(0, 64'h1_0005_0000);
        cmp(nv_out[0], 64'h1_0005_0000);
        cmd(2'h2, 2'h2);
        $display("test commands done");
        wb(1'b1, 8'h10, 32'h121);
        cmd(2'h3, 2'h0);
        upd(32'h0004_0000);
        grp <= 1'b1;
        upd(32'h0001_0000);
        tot_chk(0, 64'h5_0000);
        tot_chk(1, 64'h4_0000);
        wb(1'b1, 8'h10, 32'h221);
        upd(32'h0001_0000);
        tot_chk(1, 64'h8_0000);
        grp <= 1'b0;
        $display("test fail_mode done");
        wb(1'b1, 8'h00, 32'h1);
        cmd(2'h2, 2'h0);
        wb(1'b1, 8'h10, 32'h21);
        cmp(nv_out[1], 64'h8_0000);
        rd_chk(8'h10, 32'h221);
        wb(1'b1, 8'h00, 32'h0);
        $display("test batch done");
        repeat (70) @(posedge i_clk);
        cmp({63'h0, wd_err}, 64'h1);
        upd(32'h0004_0000);
        cmp({63'h0, wd_err}, 64'h0);
        nv_in   <= {64'h0001_2345_6789_ABCD, 64'h3_0000};
        nv_load <= 1'b1;
        @(posedge i_clk);
        nv_load <= 1'b0;
        upd(32'h0);
        tot_chk(0, 64'h3_0000);
        tot_chk(1, 64'h0001_2345_6789_ABCD);
        rd_chk(8'hA4, 32'h3_0000);
        $display("test watchdog_nv done");
        wrap_up();
    end
endmodule
